// ==== logic/stlc_bound_cmp.sv ====
// one inclusive signed bound compare against the actual position
// assumes position and bound are on the same clock, purely combinational
`timescale 1ns/1ps
`default_nettype none
module stlc_bound_cmp (
    input wire logic [63:0] pos_i,
    input wire logic [63:0] bound_i,
    input wire logic is_upper_i,
    input wire logic enable_i,
    output logic hit_o
);
    // signed views of the two operands
    logic signed [63:0] pos_s;
    logic signed [63:0] bnd_s;
    assign pos_s = pos_i;
    assign bnd_s = bound_i;

    // at or beyond upper, at or below lower; idle when disabled
    always_comb begin
        if (!enable_i) begin
            hit_o = 1'b0;
        end else if (is_upper_i) begin
            hit_o = (pos_s >= bnd_s);
        end else begin
            hit_o = (pos_s <= bnd_s);
        end
    end
endmodule
`default_nettype wire

// ==== logic/stlc_pkg.sv ====
// constants, register map and helpers for the software travel limit compare
// assumes one 10 MHz control clock and a 16-bit parameter index bus
package stlc_pkg;
    // parameter index of each register
    localparam logic [15:0] STLC_ADDR_ENABLE = 16'h02fc;
    localparam logic [15:0] STLC_ADDR_LIMIT_A = 16'h02fe;
    localparam logic [15:0] STLC_ADDR_LIMIT_B = 16'h0302;
    localparam logic [15:0] STLC_ADDR_STATE = 16'h0306;
    // values after reset
    localparam logic [1:0] STLC_ENABLE_RST = 2'h0;
    localparam logic [63:0] STLC_LIMIT_A_RST = 64'h0000000000000000;
    localparam logic [63:0] STLC_LIMIT_B_RST = 64'h0000000000000000;
    localparam logic [7:0] STLC_STATE_RST = 8'h00;
    // field positions
    localparam int STLC_EN_A_BIT = 0;
    localparam int STLC_EN_B_BIT = 1;
    localparam logic [15:0] STLC_ENABLE_MAX = 16'h0003;
    // accepted limit range is 54-bit signed: bits 63..53 equal
    localparam int STLC_RANGE_MSB = 53;
    // control cycle timing
    localparam int STLC_CLK_HZ = 10000000;
    localparam int STLC_CTRL_CYCLE_US = 250;
    localparam int STLC_CTRL_CYCLE_CLKS = STLC_CTRL_CYCLE_US * (STLC_CLK_HZ / 1000000);

    // true when a signed 64-bit value lies inside the accepted range
    function automatic logic stlc_in_range(input logic [63:0] v);
        stlc_in_range = (&v[63:STLC_RANGE_MSB]) | ~(|v[63:STLC_RANGE_MSB]);
    endfunction
endpackage

// ==== logic/stlc_top.sv ====
// software travel limit compare: parameter registers, bound selection,
// control-cycle compare and merge with the hardware limit switches
// assumes actual position and homed flag come from logic on CLK_SYS_I,
// hardware limit switch inputs come straight from pins
`timescale 1ns/1ps
`default_nettype none
module stlc_top
    import stlc_pkg::*;
#(
    parameter int CTRL_CYCLE_CLKS = STLC_CTRL_CYCLE_CLKS
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // parameter access port
    input wire logic [15:0] PAR_ADDR_I,
    input wire logic PAR_WR_I,
    input wire logic PAR_RD_I,
    input wire logic [63:0] PAR_WDATA_I,
    output logic [63:0] PAR_RDATA_O,
    output logic PAR_ACK_O,
    output logic PAR_ERR_O,
    // position loop side
    input wire logic [63:0] ACT_POS_I,
    input wire logic AXIS_HOMED_I,
    // hardware limit switch pins
    input wire logic HW_LIMIT_POS_I,
    input wire logic HW_LIMIT_NEG_I,
    // results
    output logic [7:0] LIMIT_STATE_O,
    output logic POS_LIMIT_O,
    output logic NEG_LIMIT_O,
    output logic CTRL_TICK_O
);
    // divider width and last divider count
    localparam int CNT_W = $clog2(CTRL_CYCLE_CLKS + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CTRL_CYCLE_CLKS - 1);

    logic [1:0] enable_r; // only two meaningful bits are stored
    logic [63:0] limit_a_r; // signed limit A position
    logic [63:0] limit_b_r; // signed limit B position
    logic [7:0] state_r; // published limit state word
    logic a_upper_r; // role of limit A at last compare
    logic [CNT_W-1:0] cnt_r; // control cycle divider
    logic tick_r; // one-cycle control cycle enable
    logic hw_pos_m_r, hw_pos_s_r; // pin synchroniser, positive switch
    logic hw_neg_m_r, hw_neg_s_r; // pin synchroniser, negative switch
    logic [63:0] rdata_r;
    logic ack_r;
    logic err_r;
    logic pos_lim_r;
    logic neg_lim_r;

    logic both_en; // dual mode
    logic a_upper_nxt; // limit A acts as upper bound
    logic hit_a, hit_b; // raw compare results
    logic sw_up_hit, sw_dn_hit; // software hits by direction
    logic wr_ok; // write accepted
    logic [63:0] rd_val; // decoded read value
    logic rd_hit; // read address mapped

    // divider for the control cycle enable
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else if (cnt_r == CNT_LAST) begin
            cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + CNT_W'(1);
            tick_r <= 1'b0;
        end
    end

    // two-stage synchronisers for the switch pins
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            hw_pos_m_r <= 1'b0;
            hw_pos_s_r <= 1'b0;
            hw_neg_m_r <= 1'b0;
            hw_neg_s_r <= 1'b0;
        end else begin
            hw_pos_m_r <= HW_LIMIT_POS_I;
            hw_pos_s_r <= hw_pos_m_r;
            hw_neg_m_r <= HW_LIMIT_NEG_I;
            hw_neg_s_r <= hw_neg_m_r;
        end
    end

    // write acceptance: enable limited to 0..3, limits to the legal range
    always_comb begin
        wr_ok = 1'b0;
        case (PAR_ADDR_I)
            STLC_ADDR_ENABLE: wr_ok = (PAR_WDATA_I <= 64'(STLC_ENABLE_MAX));
            STLC_ADDR_LIMIT_A: wr_ok = stlc_in_range(PAR_WDATA_I);
            STLC_ADDR_LIMIT_B: wr_ok = stlc_in_range(PAR_WDATA_I);
            default: wr_ok = 1'b0; // state word is read only
        endcase
    end

    // setting registers; a rejected write leaves the old value
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            enable_r <= STLC_ENABLE_RST;
            limit_a_r <= STLC_LIMIT_A_RST;
            limit_b_r <= STLC_LIMIT_B_RST;
        end else if (PAR_WR_I && wr_ok) begin
            case (PAR_ADDR_I)
                STLC_ADDR_ENABLE: enable_r <= PAR_WDATA_I[1:0];
                STLC_ADDR_LIMIT_A: limit_a_r <= PAR_WDATA_I;
                STLC_ADDR_LIMIT_B: limit_b_r <= PAR_WDATA_I;
                default: enable_r <= enable_r;
            endcase
        end
    end

    // read decode; narrower registers zero-extended
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (PAR_ADDR_I)
            STLC_ADDR_ENABLE: rd_val = {62'h0, enable_r};
            STLC_ADDR_LIMIT_A: rd_val = limit_a_r;
            STLC_ADDR_LIMIT_B: rd_val = limit_b_r;
            STLC_ADDR_STATE: rd_val = {56'h0, state_r};
            default: rd_hit = 1'b0; // unmapped index
        endcase
    end

    // answer one cycle after the strobe; write wins if both are raised
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_r <= '0;
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end else if (PAR_WR_I) begin
            ack_r <= 1'b1;
            err_r <= ~wr_ok;
        end else if (PAR_RD_I) begin
            rdata_r <= rd_val;
            ack_r <= 1'b1;
            err_r <= ~rd_hit;
        end else begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
        end
    end

    // bound roles; equal values leave A as the lower bound
    assign both_en = enable_r[STLC_EN_A_BIT] & enable_r[STLC_EN_B_BIT];
    assign a_upper_nxt = both_en & ($signed(limit_a_r) > $signed(limit_b_r));

    // limit A compare, gated by its enable bit and homing
    stlc_bound_cmp u_cmp_a (
        .pos_i(ACT_POS_I),
        .bound_i(limit_a_r),
        .is_upper_i(a_upper_nxt),
        .enable_i(enable_r[STLC_EN_A_BIT] & AXIS_HOMED_I),
        .hit_o(hit_a)
    );

    // limit B compare takes the opposite role of A
    stlc_bound_cmp u_cmp_b (
        .pos_i(ACT_POS_I),
        .bound_i(limit_b_r),
        .is_upper_i(~a_upper_nxt),
        .enable_i(enable_r[STLC_EN_B_BIT] & AXIS_HOMED_I),
        .hit_o(hit_b)
    );

    // state word: cleared at once on loss of homing, else per control cycle
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            state_r <= STLC_STATE_RST;
            a_upper_r <= 1'b0;
        end else if (!AXIS_HOMED_I) begin
            state_r <= STLC_STATE_RST;
        end else if (tick_r) begin
            state_r <= {6'h00, hit_b, hit_a};
            a_upper_r <= a_upper_nxt;
        end
    end

    // software hits sorted by direction of travel
    assign sw_up_hit = (state_r[0] & a_upper_r) | (state_r[1] & ~a_upper_r);
    assign sw_dn_hit = (state_r[0] & ~a_upper_r) | (state_r[1] & a_upper_r);

    // merged limits: either source stops travel, neither masks the other
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            pos_lim_r <= 1'b0;
            neg_lim_r <= 1'b0;
        end else begin
            pos_lim_r <= hw_pos_s_r | sw_up_hit;
            neg_lim_r <= hw_neg_s_r | sw_dn_hit;
        end
    end

    assign PAR_RDATA_O = rdata_r;
    assign PAR_ACK_O = ack_r;
    assign PAR_ERR_O = err_r;
    assign LIMIT_STATE_O = state_r;
    assign POS_LIMIT_O = pos_lim_r;
    assign NEG_LIMIT_O = neg_lim_r;
    assign CTRL_TICK_O = tick_r;
endmodule
`default_nettype wire

// ==== verification/stlc_asserts.sv ====
// port checker for the travel limit compare
// assumes one clock domain, bound onto stlc_top
`timescale 1ns/1ps
`default_nettype none
module stlc_asserts #(
    parameter int CTRL_CYCLE_CLKS = 4
) (
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    input wire logic AXIS_HOMED_I,
    input wire logic HW_LIMIT_POS_I,
    input wire logic HW_LIMIT_NEG_I,
    input wire logic [7:0] LIMIT_STATE_O,
    input wire logic POS_LIMIT_O,
    input wire logic NEG_LIMIT_O,
    input wire logic CTRL_TICK_O
);
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RST_I);
    // spare state bits never set
    state_spare_a: assert property (LIMIT_STATE_O[7:2] == 6'h00)
        else $error("spare state bits set");
    unhomed_clear_a: assert property (!AXIS_HOMED_I |=> LIMIT_STATE_O == 8'h00)
        else $error("state kept while not homed");
    // between ticks the compare result must not move
    state_hold_a: assert property (AXIS_HOMED_I && !CTRL_TICK_O |=> $stable(LIMIT_STATE_O))
        else $error("state moved off tick");
    // cycles since the last tick; a counter, since the real period is far beyond a delay
    logic [31:0] gap_r;
    // restarts at each tick, counts up in between
    always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
            gap_r <= 32'h0;
        end else if (CTRL_TICK_O) begin
            gap_r <= 32'h1;
        end else begin
            gap_r <= gap_r + 32'h1;
        end
    end
    tick_period_a: assert property (CTRL_TICK_O |-> gap_r == 32'(CTRL_CYCLE_CLKS))
        else $error("tick period wrong");
    tick_single_a: assert property (CTRL_TICK_O |=> !CTRL_TICK_O)
        else $error("tick longer than one cycle");
    // switch pins pass through two sync stages and the output flop
    // the release edge still clears the synchroniser, so it does not count
    hw_pos_a: assert property ((HW_LIMIT_POS_I && !RST_I) [*3] |=> POS_LIMIT_O)
        else $error("upper switch not seen");
    hw_neg_a: assert property ((HW_LIMIT_NEG_I && !RST_I) [*3] |=> NEG_LIMIT_O)
        else $error("lower switch not seen");
    sw_hit_a: assert property (|LIMIT_STATE_O[1:0] |=> POS_LIMIT_O || NEG_LIMIT_O)
        else $error("active limit not on outputs");
    quiet_pos_a: assert property ((!HW_LIMIT_POS_I [*3] ##0 LIMIT_STATE_O == 8'h00)
        |=> !POS_LIMIT_O)
        else $error("upper limit without cause");
endmodule
bind stlc_top stlc_asserts #(.CTRL_CYCLE_CLKS(CTRL_CYCLE_CLKS)) chk_u (
    .CLK_SYS_I(CLK_SYS_I),
    .RST_I(RST_I),
    .AXIS_HOMED_I(AXIS_HOMED_I),
    .HW_LIMIT_POS_I(HW_LIMIT_POS_I),
    .HW_LIMIT_NEG_I(HW_LIMIT_NEG_I),
    .LIMIT_STATE_O(LIMIT_STATE_O),
    .POS_LIMIT_O(POS_LIMIT_O),
    .NEG_LIMIT_O(NEG_LIMIT_O),
    .CTRL_TICK_O(CTRL_TICK_O)
);
`default_nettype wire

// ==== verification/stlc_pos_loop.sv ====
// position loop model: actual position and homed flag
// assumes commands from the bench on the same clock
`timescale 1ns/1ps
`default_nettype none
module stlc_pos_loop (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [63:0] pos_cmd_i,
    input wire logic homed_cmd_i,
    output logic [63:0] act_pos_o,
    output logic homed_o
);
    // one cycle of loop delay, so position never moves on a bench edge
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            act_pos_o <= 64'h0;
            homed_o <= 1'b0;
        end else begin
            act_pos_o <= pos_cmd_i;
            homed_o <= homed_cmd_i;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the travel limit compare
// assumes a short control cycle of four clocks
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import stlc_pkg::*;
;
    localparam int CYC = 4;
    typedef struct packed {
        logic [1:0] en;
        logic [63:0] a, b, pos;
        logic [1:0] st, pn;
    } stlc_row_type;
    // enable, A, B, position, state, {upper, lower}
    stlc_row_type rows [6] = '{
        '{2'h0, -64'h0a, 64'h0a, 64'h14, 2'h0, 2'h0},
        '{2'h2, -64'h0a, 64'h0a, 64'h0a, 2'h2, 2'h2},
        '{2'h3, 64'h0a, -64'h0a, 64'h0a, 2'h1, 2'h2},
        '{2'h3, 64'h0a, -64'h0a, -64'h0b, 2'h2, 2'h1},
        '{2'h1, -64'h0a, 64'h0a, 64'h14, 2'h0, 2'h0},
        '{2'h1, -64'h0a, 64'h0a, -64'h0a, 2'h1, 2'h1}};
    logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, homed_cmd = 1'b0;
    logic hwp = 1'b0, hwn = 1'b0, ack, err, homed, tick, posl, negl;
    logic [15:0] addr = 16'h0;
    logic [63:0] wdata = 64'h0, pos_cmd = 64'h0, rdata, act_pos;
    logic [7:0] state;
    int failures = 0, n_compared = 0, cyc = 0;
    always #50 clk = ~clk;
    stlc_pos_loop loop_u (.clk_i(clk), .rst_i(rst), .pos_cmd_i(pos_cmd),
        .homed_cmd_i(homed_cmd), .act_pos_o(act_pos), .homed_o(homed));
    stlc_top #(.CTRL_CYCLE_CLKS(CYC)) dut_u (.CLK_SYS_I(clk), .RST_I(rst),
        .PAR_ADDR_I(addr), .PAR_WR_I(wr), .PAR_RD_I(rd), .PAR_WDATA_I(wdata),
        .PAR_RDATA_O(rdata), .PAR_ACK_O(ack), .PAR_ERR_O(err), .ACT_POS_I(act_pos),
        .AXIS_HOMED_I(homed), .HW_LIMIT_POS_I(hwp), .HW_LIMIT_NEG_I(hwn),
        .LIMIT_STATE_O(state), .POS_LIMIT_O(posl), .NEG_LIMIT_O(negl), .CTRL_TICK_O(tick));
    task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one strobe cycle, answer looked at once it has settled
    task automatic acc(input logic w, input logic [15:0] ad, input logic [63:0] d,
        input logic e);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        chk("ack", 64'h1, {63'h0, ack});
        chk("err", {63'h0, e}, {63'h0, err});
    endtask
    task automatic tally_and_finish;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // a hang is cut short well past the expected run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        homed_cmd <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            acc(1'b1, STLC_ADDR_ENABLE, {62'h0, rows[i].en}, 1'b0);
            acc(1'b1, STLC_ADDR_LIMIT_A, rows[i].a, 1'b0);
            acc(1'b1, STLC_ADDR_LIMIT_B, rows[i].b, 1'b0);
            @(posedge clk);
            pos_cmd <= rows[i].pos;
            repeat (3 * CYC) @(posedge clk);
            #1;
            chk("state", {62'h0, rows[i].st}, {56'h0, state});
            chk("limits", {62'h0, rows[i].pn}, {62'h0, posl, negl});
            acc(1'b0, STLC_ADDR_STATE, 64'h0, 1'b0);
            chk("state read", {62'h0, rows[i].st}, rdata);
            $display("row %0d done", i);
        end
        // losing home clears a live hit without waiting for a tick
        @(posedge clk);
        homed_cmd <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("unhomed", 64'h0, {56'h0, state});
        @(posedge clk);
        hwp <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("hw limits", 64'h2, {62'h0, posl, negl});
        // lower switch joins; the upper one must stay shown
        @(posedge clk);
        hwn <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chk("hw both limits", 64'h3, {62'h0, posl, negl});
        $display("homing and switch test done");
        acc(1'b1, STLC_ADDR_ENABLE, 64'h4, 1'b1);
        acc(1'b1, STLC_ADDR_LIMIT_A, 64'h0020000000000000, 1'b1);
        acc(1'b1, STLC_ADDR_LIMIT_A, 64'h001fffffffffffff, 1'b0);
        acc(1'b1, STLC_ADDR_LIMIT_B, 64'hffe0000000000000, 1'b0);
        acc(1'b1, STLC_ADDR_STATE, 64'h1, 1'b1);
        acc(1'b0, STLC_ADDR_ENABLE, 64'h0, 1'b0);
        chk("enable kept", 64'h1, rdata);
        acc(1'b0, STLC_ADDR_LIMIT_A, 64'h0, 1'b0);
        chk("limit a max", 64'h001fffffffffffff, rdata);
        acc(1'b0, STLC_ADDR_LIMIT_B, 64'h0, 1'b0);
        chk("limit b min", 64'hffe0000000000000, rdata);
        acc(1'b0, 16'h0300, 64'h0, 1'b1);
        chk("unmapped", 64'h0, rdata);
        $display("refusal test done");
        // second reset in mid-run, then the enable and limit A reset values
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        acc(1'b0, STLC_ADDR_ENABLE, 64'h0, 1'b0);
        chk("enable reset", 64'h0, rdata);
        acc(1'b0, STLC_ADDR_LIMIT_A, 64'h0, 1'b0);
        chk("limit a reset", 64'h0, rdata);
        $display("reset test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
